// ---- core/tss_pkg.sv ----
// Shared constants and carriers of the trigger and sequence supervisor.
// Assumes a single 125 MHz system clock and an AHB-Lite register port.
package tss_pkg;

  // ---------------------------------------------
  // Register map
  // ---------------------------------------------
  localparam logic [7:0] TSS_CTRL_OFS = 8'h00;
  localparam logic [7:0] TSS_STAT_OFS = 8'h04;
  localparam logic [7:0] TSS_CNT_OFS = 8'h08;
  localparam int TSS_WIN_W = 5;
  localparam int TSS_SEQ_CNT_W = 8;
  localparam int TSS_LONG_CNT_W = 9;
  localparam int TSS_SHORT_CNT_W = 8;
  localparam logic [4:0] TSS_WIN_RST = 5'h10;
  localparam logic [7:0] TSS_SEQ_LOAD = 8'hFF;
  localparam logic [8:0] TSS_LONG_LOAD = 9'h1FF;
  localparam logic [7:0] TSS_SHORT_LOAD = 8'hFF;
  localparam logic [1:0] TSS_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] TSS_HSIZE_WORD = 3'h2;

  // ---------------------------------------------
  // Carriers
  // ---------------------------------------------
  typedef struct packed {
    logic reload;
    logic mode_two;
    logic mode_one;
    logic [TSS_WIN_W-1:0] window;
  } tss_ctrl_t;

  typedef struct packed {
    logic fifo_overflow;
    logic write_address_inhibit;
    logic trigger_inhibit_two;
    logic trigger_inhibit_one;
    logic readout_error_inhibit;
    logic seq_error;
    logic seq_error_pending;
    logic close_trigger_flag;
    logic first_trigger;
  } tss_stat_t;

  typedef struct packed {
    logic [7:0] address;
    logic valid;
  } tss_addr_t;

  localparam tss_ctrl_t TSS_CTRL_RST = '{reload: 1'b0, mode_two: 1'b0,
    mode_one: 1'b0, window: TSS_WIN_RST};

endpackage

// ---- core/tss_top.sv ----
// Trigger and sequence supervisor of a pipeline-memory address controller.
// Assumes single-cycle taps and strobes from the readout and sequencer logic,
// all synchronous to clk_sys_i, and a read clock sampled as a plain input.
`timescale 1ns/1ps
`default_nettype none

module tss_top import tss_pkg::*; #(
  parameter int FIFO_DEPTH = 16,
  parameter logic [7:0] TOP_ADDRESS = 8'hFF
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // Trigger and readout side
  input wire logic trigger_in_i,
  input wire logic read_clock_i,
  input wire logic end_of_read_cycle_i,
  input wire logic read_fifo_push_i,
  input wire logic write_fifo_write_enable_bit_i,
  input wire logic [7:0] freed_address_i,
  input wire logic readout_tap_a_i,
  input wire logic readout_tap_b_i,
  input wire logic readout_tap_c_i,
  input wire logic done_fifo_push_i,
  // Address sequencer side
  input wire logic [7:0] seq_address_i,
  input wire logic seq_address_valid_i,
  input wire logic done_fifo_pop_i,
  output logic done_fifo_available_o,
  output logic [7:0] returned_address_o,
  output logic [7:0] write_address_o,
  output logic write_address_valid_o,
  // Flags and inhibits
  output logic close_trigger_flag_out_o,
  output logic sequence_error_o,
  output logic trigger_inhibit_one_o,
  output logic trigger_inhibit_two_o,
  output logic write_address_inhibit_o,
  output logic release_enable_pulse_o
);

  localparam int PTR_W = $clog2(FIFO_DEPTH);

  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin
    $error("FIFO_DEPTH must be a power of two of at least 2");
  end

  function automatic logic [7:0] next_addr(input logic [7:0] a);
    next_addr = (a == TOP_ADDRESS) ? 8'h00 : a + 8'h01;
  endfunction

  // ---------------------------------------------
  // Register port
  // ---------------------------------------------
  tss_ctrl_t ctrl_ff;
  tss_stat_t stat;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic [4:0] win_cnt_ff;
  logic [7:0] seq_cnt_ff;
  logic [8:0] long_cnt_ff;
  logic [7:0] short_cnt_ff;

  wire logic addr_phase = hsel_i && htrans_i == TSS_HTRANS_NONSEQ && hready_i;
  wire logic word_acc = hsize_i == TSS_HSIZE_WORD;
  wire logic [7:0] acc_ofs = haddr_i[7:0];
  wire logic ctrl_wr = wr_pend_ff && wr_addr_ff == TSS_CTRL_OFS;
  wire logic [31:0] rd_mux =
    (acc_ofs == TSS_CTRL_OFS) ? {24'h000000, ctrl_ff} :
    (acc_ofs == TSS_STAT_OFS) ? {23'h000000, stat} :
    (acc_ofs == TSS_CNT_OFS) ?
      {2'h0, win_cnt_ff, seq_cnt_ff, long_cnt_ff, short_cnt_ff} : 32'h00000000;

  // Zero wait states keeps the slave trivially compliant
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_ff;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff <= 32'h00000000;
    end else begin
      wr_pend_ff <= addr_phase && hwrite_i && word_acc;
      wr_addr_ff <= acc_ofs;
      if (addr_phase && !hwrite_i) begin
        hrdata_ff <= word_acc ? rd_mux : 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_ff <= TSS_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_ff <= tss_ctrl_t'(hwdata_i[$bits(tss_ctrl_t)-1:0]);
    end
  end

  wire logic reload_and_reset = ctrl_ff.reload;

  // ---------------------------------------------
  // Close-trigger window
  // ---------------------------------------------
  logic first_ff, close_ff;
  wire logic win_term = first_ff && win_cnt_ff == 5'h00;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      first_ff <= 1'b0;
      close_ff <= 1'b0;
      win_cnt_ff <= TSS_WIN_RST;
    end else if (reload_and_reset || win_term) begin
      first_ff <= 1'b0;
      close_ff <= 1'b0;
      win_cnt_ff <= ctrl_ff.window;
    end else if (!first_ff) begin
      win_cnt_ff <= ctrl_ff.window;
      first_ff <= trigger_in_i;
    end else begin
      win_cnt_ff <= win_cnt_ff - 5'h01;
      if (trigger_in_i) begin
        close_ff <= 1'b1;
      end
    end
  end

  assign close_trigger_flag_out_o = close_ff;

  // ---------------------------------------------
  // Read-complete latches and FIFO
  // ---------------------------------------------
  logic [7:0] stage_a_ff, stage_b_ff, stage_c_ff, cap_rise_ff, cap_fall_ff;
  logic [7:0] fifo_mem [FIFO_DEPTH];
  logic [PTR_W:0] wptr_ff, rptr_ff;
  logic ovf_ff;

  wire logic fifo_empty = wptr_ff == rptr_ff;
  wire logic fifo_full = wptr_ff == {~rptr_ff[PTR_W], rptr_ff[PTR_W-1:0]};
  wire logic do_push = done_fifo_push_i && !fifo_full && !reload_and_reset;
  wire logic do_pop = done_fifo_pop_i && !fifo_empty && !reload_and_reset;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stage_a_ff <= 8'h00;
      stage_b_ff <= 8'h00;
      stage_c_ff <= 8'h00;
    end else begin
      if (readout_tap_a_i) stage_a_ff <= freed_address_i;
      if (readout_tap_b_i) stage_b_ff <= stage_a_ff;
      if (readout_tap_c_i) stage_c_ff <= stage_b_ff;
    end
  end

  // Memory has no reset so it can map onto RAM
  always_ff @(posedge clk_sys_i) begin
    if (do_push) fifo_mem[wptr_ff[PTR_W-1:0]] <= stage_c_ff;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      ovf_ff <= 1'b0;
      cap_rise_ff <= 8'h00;
    end else if (reload_and_reset) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      ovf_ff <= 1'b0;
    end else begin
      if (do_push) wptr_ff <= wptr_ff + 1'b1;
      if (do_pop) begin
        rptr_ff <= rptr_ff + 1'b1;
        cap_rise_ff <= fifo_mem[rptr_ff[PTR_W-1:0]];
      end
      // Pushes into a full FIFO are lost; flag it for software
      if (done_fifo_push_i && fifo_full) ovf_ff <= 1'b1;
    end
  end

  // Second capture on the falling edge gives the sequencer a half-cycle margin
  always_ff @(negedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cap_fall_ff <= 8'h00;
    end else begin
      cap_fall_ff <= cap_rise_ff;
    end
  end

  assign done_fifo_available_o = !fifo_empty;
  assign returned_address_o = cap_fall_ff;

  // ---------------------------------------------
  // Sequence checker
  // ---------------------------------------------
  logic [7:0] last_addr_ff;
  logic last_valid_ff, pend_ff, seq_err_ff, readout_error_inhibit_ff;

  wire logic seq_block = reload_and_reset || !write_fifo_write_enable_bit_i || readout_error_inhibit_ff;
  wire logic seq_bad = seq_address_valid_i && last_valid_ff &&
    seq_address_i != next_addr(last_addr_ff) && !seq_block;
  wire logic seq_term = pend_ff && seq_cnt_ff == 8'h00;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      last_addr_ff <= 8'h00;
      last_valid_ff <= 1'b0;
    end else if (reload_and_reset) begin
      last_valid_ff <= 1'b0;
    end else if (seq_address_valid_i) begin
      last_addr_ff <= seq_address_i;
      last_valid_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_ff <= 1'b0;
      seq_err_ff <= 1'b0;
      seq_cnt_ff <= TSS_SEQ_LOAD;
    end else if (reload_and_reset) begin
      pend_ff <= 1'b0;
      seq_err_ff <= 1'b0;
      seq_cnt_ff <= TSS_SEQ_LOAD;
    end else if (seq_bad && pend_ff) begin
      seq_err_ff <= 1'b1;
    end else if (seq_bad) begin
      pend_ff <= 1'b1;
      seq_cnt_ff <= TSS_SEQ_LOAD;
    end else if (seq_term) begin
      pend_ff <= 1'b0;
      seq_cnt_ff <= TSS_SEQ_LOAD;
    end else if (pend_ff) begin
      seq_cnt_ff <= seq_cnt_ff - 8'h01;
    end
  end

  assign sequence_error_o = seq_err_ff;

  // ---------------------------------------------
  // Inhibit and release
  // ---------------------------------------------
  logic push_d_ff, rclk_d_ff, eorc_ff, eorc_d_ff, ebp_ff;
  logic inh1_ff, inh2_ff, wainh_ff, long_run_ff, short_run_ff;

  wire logic push_rise = read_fifo_push_i && !push_d_ff;
  wire logic rclk_rise = read_clock_i && !rclk_d_ff;
  wire logic eorc_fall = eorc_d_ff && !eorc_ff;
  wire logic release_enable_pulse = eorc_fall && !read_fifo_push_i;
  wire logic long_term = long_run_ff && long_cnt_ff == 9'h000;
  wire logic short_term = short_run_ff && short_cnt_ff == 8'h00;
  wire logic any_mode = ctrl_ff.mode_one || ctrl_ff.mode_two;

  // End-of-read is only looked at on read clock rising edges
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      push_d_ff <= 1'b0;
      rclk_d_ff <= 1'b0;
      eorc_ff <= 1'b0;
      eorc_d_ff <= 1'b0;
      ebp_ff <= 1'b0;
    end else begin
      push_d_ff <= read_fifo_push_i;
      rclk_d_ff <= read_clock_i;
      if (rclk_rise) eorc_ff <= end_of_read_cycle_i;
      eorc_d_ff <= eorc_ff;
      ebp_ff <= release_enable_pulse && !reload_and_reset;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      readout_error_inhibit_ff <= 1'b0;
      inh1_ff <= 1'b0;
      inh2_ff <= 1'b0;
      wainh_ff <= 1'b0;
    end else if (reload_and_reset) begin
      readout_error_inhibit_ff <= 1'b0;
      inh1_ff <= 1'b0;
      inh2_ff <= 1'b0;
      wainh_ff <= 1'b0;
    end else if (push_rise) begin
      readout_error_inhibit_ff <= 1'b1;
      inh1_ff <= inh1_ff || ctrl_ff.mode_one;
      inh2_ff <= inh2_ff || ctrl_ff.mode_two;
      wainh_ff <= wainh_ff || ctrl_ff.mode_two;
    end else begin
      if (long_term) begin
        inh2_ff <= 1'b0;
        readout_error_inhibit_ff <= 1'b0;
      end
      if (short_term) begin
        inh1_ff <= 1'b0;
        wainh_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      long_run_ff <= 1'b0;
      short_run_ff <= 1'b0;
      long_cnt_ff <= TSS_LONG_LOAD;
      short_cnt_ff <= TSS_SHORT_LOAD;
    end else if (reload_and_reset) begin
      long_run_ff <= 1'b0;
      short_run_ff <= 1'b0;
      long_cnt_ff <= TSS_LONG_LOAD;
      short_cnt_ff <= TSS_SHORT_LOAD;
    end else begin
      if (ebp_ff) begin
        long_run_ff <= 1'b1;
        long_cnt_ff <= TSS_LONG_LOAD;
      end else if (long_term) begin
        long_run_ff <= 1'b0;
      end else if (long_run_ff) begin
        long_cnt_ff <= long_cnt_ff - 9'h001;
      end
      if (ebp_ff && any_mode) begin
        short_run_ff <= 1'b1;
        short_cnt_ff <= TSS_SHORT_LOAD;
      end else if (short_term) begin
        short_run_ff <= 1'b0;
      end else if (short_run_ff) begin
        short_cnt_ff <= short_cnt_ff - 8'h01;
      end
    end
  end

  assign release_enable_pulse_o = ebp_ff;
  assign trigger_inhibit_one_o = inh1_ff;
  assign trigger_inhibit_two_o = inh2_ff;
  assign write_address_inhibit_o = wainh_ff;

  // ---------------------------------------------
  // Write address path
  // ---------------------------------------------
  tss_addr_t wa_ff;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wa_ff <= '0;
    end else if (wainh_ff) begin
      wa_ff.valid <= 1'b0;
    end else begin
      wa_ff <= '{address: seq_address_i, valid: seq_address_valid_i};
    end
  end

  assign write_address_o = wa_ff.address;
  assign write_address_valid_o = wa_ff.valid;

  // ---------------------------------------------
  // Status view
  // ---------------------------------------------
  assign stat = '{fifo_overflow: ovf_ff, write_address_inhibit: wainh_ff,
    trigger_inhibit_two: inh2_ff, trigger_inhibit_one: inh1_ff, readout_error_inhibit: readout_error_inhibit_ff,
    seq_error: seq_err_ff, seq_error_pending: pend_ff, close_trigger_flag: close_ff,
    first_trigger: first_ff};

endmodule

`default_nettype wire

// ---- testbench/tss_checker.sv ----
// Port checker for the trigger and sequence supervisor.
// Assumes it is bound to tss_top and runs on clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module tss_checker (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic trigger_in_i,
  input wire logic read_fifo_push_i,
  input wire logic write_fifo_write_enable_bit_i,
  input wire logic seq_address_valid_i,
  input wire logic done_fifo_pop_i,
  input wire logic [7:0] returned_address_o,
  input wire logic write_address_valid_o,
  input wire logic close_trigger_flag_out_o,
  input wire logic sequence_error_o,
  input wire logic trigger_inhibit_two_o,
  input wire logic write_address_inhibit_o,
  input wire logic release_enable_pulse_o
);
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  a_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready and okay");
  a_flag_cause: assert property ($rose(close_trigger_flag_out_o) |-> $past(trigger_in_i))
    else $error("close flag without trigger");
  a_flag_ends: assert property (close_trigger_flag_out_o |-> ##[1:33] !close_trigger_flag_out_o)
    else $error("close flag outlives window");
  a_err_cause: assert property ($rose(sequence_error_o)
    |-> $past(seq_address_valid_i && write_fifo_write_enable_bit_i))
    else $error("sequence error without checked address");
  a_ret_pop: assert property ($changed(returned_address_o) |-> $past(done_fifo_pop_i))
    else $error("returned address moved without pop");
  a_pulse_one: assert property (release_enable_pulse_o |=> !release_enable_pulse_o)
    else $error("release pulse longer than one cycle");
  a_pulse_push: assert property (release_enable_pulse_o |-> !$past(read_fifo_push_i))
    else $error("release pulse while push high");
  a_inh_rise: assert property ($rose(trigger_inhibit_two_o) |-> $past(read_fifo_push_i))
    else $error("inhibit two without push");
  a_wa_pair: assert property ($rose(write_address_inhibit_o) |-> trigger_inhibit_two_o)
    else $error("write inhibit without inhibit two");
  a_wa_gate: assert property (write_address_inhibit_o && $past(write_address_inhibit_o)
    |-> !write_address_valid_o)
    else $error("write address passed while inhibited");
  c_flag: cover property ($rose(close_trigger_flag_out_o));
  c_err: cover property ($rose(sequence_error_o));
  c_pulse: cover property (release_enable_pulse_o);
endmodule
bind tss_top tss_checker chk_u (.clk_sys_i, .sys_rst_i, .hreadyout_o, .hresp_o, .trigger_in_i,
  .read_fifo_push_i, .write_fifo_write_enable_bit_i, .seq_address_valid_i, .done_fifo_pop_i,
  .returned_address_o, .write_address_valid_o, .close_trigger_flag_out_o, .sequence_error_o,
  .trigger_inhibit_two_o, .write_address_inhibit_o, .release_enable_pulse_o);
`default_nettype wire

// ---- testbench/tss_seq_model.sv ----
// Address sequencer model: steps write addresses and pops freed ones.
// Assumes the done FIFO available flag is combinational.
`timescale 1ns/1ps
`default_nettype none
module tss_seq_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic skip_i,
  input wire logic avail_i,
  output logic pop_o,
  output logic [7:0] addr_o,
  output logic valid_o
);
  // ----
  // Sequencer
  // ----
  logic tick_ff;
  logic [7:0] nxt_addr;
  // Skip jumps by two so that the supervisor sees one bad step
  assign nxt_addr = addr_o + (skip_i ? 8'h02 : 8'h01);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_ff <= 1'b0;
      addr_o <= 8'h00;
      valid_o <= 1'b0;
      pop_o <= 1'b0;
    end else begin
      tick_ff <= ~tick_ff;
      valid_o <= run_i & tick_ff;
      if (run_i & tick_ff) begin
        addr_o <= nxt_addr;
      end
      pop_o <= avail_i & ~pop_o;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench of the trigger and sequence supervisor.
// Assumes the checker is bound and the sequencer model is alongside.
`timescale 1ns/1ps
`default_nettype none
module testbench import tss_pkg::*;;
  localparam logic [31:0] A_CTRL = 32'(TSS_CTRL_OFS);
  localparam logic [31:0] A_STAT = 32'(TSS_STAT_OFS);
  logic clk_sys_i = 0, sys_rst_i = 1, hsel = 0, hwrite = 0, trig = 0, rclk = 0, eor = 0;
  logic push = 0, write_fifo_write_enable_bit = 0, ta = 0, tb = 0, tc = 0, dpush = 0, run = 0, skip = 0;
  logic [31:0] haddr = 0, hwdata = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic [7:0] freed = 0;
  logic [4:0] rdiv = 0;
  wire logic hready, hresp, pop, sval, avail, wav, flag, serr, inh1, inh2, winh, rep;
  wire logic [31:0] hrdata;
  wire logic [7:0] saddr, ret, wa;
  int num_errors = 0, checks = 0, pulses = 0;
  tss_top dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .trigger_in_i(trig), .read_clock_i(rclk), .end_of_read_cycle_i(eor),
    .read_fifo_push_i(push), .write_fifo_write_enable_bit_i(write_fifo_write_enable_bit), .freed_address_i(freed),
    .readout_tap_a_i(ta), .readout_tap_b_i(tb), .readout_tap_c_i(tc),
    .done_fifo_push_i(dpush), .seq_address_i(saddr), .seq_address_valid_i(sval),
    .done_fifo_pop_i(pop), .done_fifo_available_o(avail), .returned_address_o(ret),
    .write_address_o(wa), .write_address_valid_o(wav), .close_trigger_flag_out_o(flag),
    .sequence_error_o(serr), .trigger_inhibit_one_o(inh1), .trigger_inhibit_two_o(inh2),
    .write_address_inhibit_o(winh), .release_enable_pulse_o(rep));
  tss_seq_model seq_u (.clk_i(clk_sys_i), .rst_i(sys_rst_i), .run_i(run), .skip_i(skip),
    .avail_i(avail), .pop_o(pop), .addr_o(saddr), .valid_o(sval));
  // ----
  // Clocks and helpers
  // ----
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // Read clock near 5 MHz, only ever sampled by the block
  always @(posedge clk_sys_i) begin
    rdiv <= (rdiv == 5'h0B) ? 5'h00 : rdiv + 5'h01;
    if (rdiv == 5'h0B) rclk <= ~rclk;
    if (rep === 1'b1) pulses++;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r);
    @(posedge clk_sys_i);
    hsel <= 1;
    htrans <= TSS_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    hsize <= TSS_HSIZE_WORD;
    do @(posedge clk_sys_i); while (hready !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys_i); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic skip_one(input int gap);
    skip <= 1;
    cyc(2);
    skip <= 0;
    cyc(gap);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic test_regs();
    logic [31:0] v;
    ahb(0, A_CTRL, 0, v);
    chk(v, 32'(TSS_CTRL_RST));
    ahb(0, A_STAT, 0, v);
    chk(v, 32'h0);
    ahb(0, 32'h40, 0, v);
    chk(v, 32'h0);
    ahb(1, A_CTRL, 32'h3, v);
    ahb(0, A_CTRL, 0, v);
    chk(v, 32'h3);
    $display("regs test over");
  endtask
  task automatic test_window();
    trig <= 1;
    cyc(1);
    trig <= 0;
    cyc(1);
    trig <= 1;
    cyc(1);
    trig <= 0;
    cyc(1);
    chk(32'(flag), 32'h1);
    cyc(2);
    chk(32'(flag), 32'h0);
    trig <= 1;
    cyc(1);
    trig <= 0;
    cyc(3);
    trig <= 1;
    cyc(1);
    trig <= 0;
    cyc(2);
    chk(32'(flag), 32'h0);
    $display("window test over");
  endtask
  task automatic test_fifo();
    logic [7:0] vals [2] = '{8'hA5, 8'h3C};
    int n;
    foreach (vals[i]) begin
      freed <= vals[i];
      ta <= 1;
      cyc(1);
      freed <= ~vals[i];
      ta <= 0;
      tb <= 1;
      cyc(1);
      tb <= 0;
      tc <= 1;
      cyc(1);
      tc <= 0;
      dpush <= 1;
      cyc(1);
      dpush <= 0;
      n = 0;
      while (ret !== vals[i] && n < 10) begin
        cyc(1);
        n++;
      end
      chk(32'(ret), 32'(vals[i]));
    end
    chk(32'(avail), 32'h0);
    $display("fifo test over");
  endtask
  task automatic test_seq();
    logic [31:0] v;
    logic [7:0] a_prev;
    logic v_prev;
    write_fifo_write_enable_bit <= 1;
    run <= 1;
    cyc(600);
    chk(32'(serr), 32'h0);
    // A clean wrap leaves neither a pending error nor an error in the status
    ahb(0, A_STAT, 0, v);
    chk(32'(v[3:2]), 32'h0);
    repeat (2) begin
      a_prev = saddr;
      v_prev = sval;
      cyc(1);
      chk(32'({wav, wa}), 32'({v_prev, a_prev}));
    end
    skip_one(20);
    ahb(0, A_STAT, 0, v);
    chk(32'(v[2]), 32'h1);
    cyc(300);
    ahb(0, A_STAT, 0, v);
    chk(32'(v[3:2]), 32'h0);
    skip_one(20);
    skip_one(4);
    chk(32'(serr), 32'h1);
    cyc(400);
    chk(32'(serr), 32'h1);
    ahb(1, A_CTRL, 32'h83, v);
    ahb(1, A_CTRL, 32'h03, v);
    cyc(2);
    chk(32'(serr), 32'h0);
    write_fifo_write_enable_bit <= 0;
    skip_one(10);
    skip_one(4);
    chk(32'(serr), 32'h0);
    write_fifo_write_enable_bit <= 1;
    $display("sequence test over");
  endtask
  task automatic test_inh();
    logic [31:0] v;
    int n;
    ahb(1, A_CTRL, 32'h70, v);
    push <= 1;
    cyc(3);
    chk(32'({inh1, inh2, winh}), 32'h7);
    chk(32'(wav), 32'h0);
    cyc(1);
    chk(32'(wav), 32'h0);
    skip_one(10);
    skip_one(4);
    chk(32'(serr), 32'h0);
    eor <= 1;
    cyc(30);
    eor <= 0;
    cyc(60);
    chk(pulses, 0);
    push <= 0;
    eor <= 1;
    cyc(30);
    eor <= 0;
    n = 0;
    while (rep !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    n = 0;
    // Bounds allow two cycles either way around 256 and four around 512
    while (inh1 !== 1'b0 && n < 400) begin
      cyc(1);
      n++;
    end
    chk(32'(n >= 254 && n <= 258), 32'h1);
    chk(32'({inh2, winh}), 32'h2);
    while (inh2 !== 1'b0 && n < 700) begin
      cyc(1);
      n++;
    end
    chk(32'(n >= 508 && n <= 516), 32'h1);
    chk(pulses, 1);
    ahb(0, A_STAT, 0, v);
    chk(32'(v[7:4]), 32'h0);
    $display("inhibit test over");
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
  initial begin
    cyc(4);
    sys_rst_i <= 0;
    test_regs();
    test_window();
    test_fifo();
    test_seq();
    test_inh();
    complete_run();
  end
endmodule
`default_nettype wire
